/* common/idc_pkg.sv */
package idc_pkg;
    // ****************************************
    // capability header
    // ****************************************
    localparam logic [7:0]  CAP_ID_VAL      = 8'h08;
    localparam logic [7:0]  CAP_TYPE_VAL    = 8'h80;
    localparam logic [7:0]  NEXT_PTR_LAST   = 8'h00;
    localparam int          IDX_LSB         = 16;
    localparam int          IDX_MSB         = 23;
    // ****************************************
    // register offsets and indexes
    // ****************************************
    localparam logic [1:0]  OFF_HEADER      = 2'h0;
    localparam logic [1:0]  OFF_DATAPORT    = 2'h1;
    localparam logic [7:0]  IDX_LAST_INTR   = 8'h01;
    localparam logic [7:0]  IDX_DEF_BASE    = 8'h10;
    localparam int          LAST_LSB        = 16;
    // ****************************************
    // definition register fields and reset
    // ****************************************
    localparam int          NUM_SRC         = 4;
    localparam int          SRC_W           = 2;
    localparam int          B_MASK          = 0;
    localparam int          B_POL           = 1;
    localparam int          B_REQUEST_END_OF_INTERRUPT         = 5;
    localparam int          B_PASS_POSTED_WRITES        = 62;
    localparam int          B_WAIT          = 63;
    localparam logic [63:0] DEF_RESET       = 64'h0000_0000_F800_0001;
    // writable bits: 62, 55:0 (61:56 reserved, 63 write-one-clear)
    localparam logic [63:0] DEF_WMASK       = 64'h40FF_FFFF_FFFF_FFFF;
endpackage

/* common/idc_src_if.sv */
`timescale 1ns/1ps
interface idc_src_if;
    logic [6:0] rd_addr;      // 2 bits source, 1 bit half... packed word addr
    logic [31:0] rd_data;     // registered read word
    modport mem  (input rd_addr, output rd_data);
    modport user (output rd_addr, input rd_data);
endinterface

/* rtl/idc_read_mux.sv */
`timescale 1ns/1ps
// registered read port over the definition words
module idc_read_mux (
    // clock and reset
    input  wire logic         core_clk,
    input  wire logic         rstn,
    // flattened definition registers
    input  wire logic [255:0] defs,
    // read port
    idc_src_if.mem            rp
);
    // ****************************************
    // read register
    // ****************************************
    // output registered so read data comes from a flop
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rp.rd_data <= 32'h0000_0000;
        end else begin
            rp.rd_data <= defs[rp.rd_addr[2:0]*32 +: 32];
        end
    end
endmodule // idc_read_mux

/* rtl/idc_top.sv */
`timescale 1ns/1ps
// Function
// R1 - capability id reads fixed 08h
// R2 - next pointer read-only, 00h when last
// R3 - capability type reads fixed 80h
// R4 - index bits 23:16 select dataport register
// R5 - software uses whole doubleword dataport accesses
// R6 - undefined index reads all zeros
// R7 - index 01h reports highest source number
// R8 - definition pairs from 10h, two per source
// R9 - even index low word, odd high
// R10 - definitions return to defaults on reset
// R11 - awaiting bit set on send, cleared eoi/w1c
// R12 - no resend while awaiting end of interrupt
// R13 - pass bit one: attribute set, unordered
// R14 - pass bit zero: wait for posted drain
// R15 - unsupported ordering makes bit read-only
// R16 - info 31:24 writable, resets F8h
// R17 - software never writes F9h or above
// R18 - message type bits 4:2 writable, reset zero
// R19 - polarity bit one means active-low input
// R20 - mask resets set, blocks messages
// R21 - active unmasked source sends one message
module idc_top #(
    parameter logic [7:0] NEXT_PTR     = idc_pkg::NEXT_PTR_LAST,
    parameter bit         PASS_POSTED_WRITES_FIXED = 1'b0,
    parameter bit         PASS_POSTED_WRITES_VALUE = 1'b0
) (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rstn,
    // configuration access, doubleword granular
    input  wire logic        cfg_rd,
    input  wire logic        cfg_wr,
    input  wire logic [1:0]  cfg_addr,
    input  wire logic [31:0] cfg_wdata,
    output logic      [31:0] cfg_rdata,
    output logic             cfg_rvalid,
    // interrupt source inputs (external pins)
    input  wire logic [3:0]  irq_in,
    // end of interrupt return, one pulse per source
    input  wire logic [3:0]  eoi_in,
    // upstream posted traffic still queued ahead
    input  wire logic        posted_pending,
    // upstream interrupt message
    output logic             msg_valid,
    input  wire logic        msg_ready,
    output logic      [55:0] msg_info,
    output logic             msg_pass_posted_writes,
    output logic      [1:0]  msg_src
);
    // ****************************************
    // state
    // ****************************************
    typedef enum logic [2:0] {
        IDC_IDLE  = 3'b001,   // scanning for requests
        IDC_ORDER = 3'b010,   // holding behind posted writes
        IDC_SEND  = 3'b100    // message on the port
    } idc_state_t;

    idc_state_t  state_ff;           // sender state
    logic [7:0]  index_ff;           // dataport index
    logic [63:0] def_ff [4];         // definition registers
    logic [3:0]  sync1_ff;           // pin sync stage 1
    logic [3:0]  sync2_ff;           // pin sync stage 2
    logic [3:0]  sync3_ff;           // pin sync stage 3
    logic [3:0]  level_ff;           // filtered pin level
    logic [3:0]  prev_ff;            // last active state
    logic [3:0]  pend_ff;            // requests waiting to go
    logic [1:0]  sel_ff;             // source being sent
    logic        rd_hdr_ff;          // read was header
    logic        rd_def_ff;          // read hit a definition
    logic [31:0] rd_fix_ff;          // non-definition read word
    logic [255:0] defs_flat;         // for the read module
    logic [3:0]  active;             // polarity-corrected level
    logic [3:0]  fire;               // new activation
    logic        dp_wr;              // dataport write
    logic        dp_def;             // index hits a definition
    logic [1:0]  dp_src;             // source from index
    logic        dp_hi;              // odd index
    logic [3:0]  eligible;           // may send now
    logic [1:0]  pick;               // lowest eligible source
    logic        sent;               // message accepted

    idc_src_if rif ();

    // ****************************************
    // decode helpers
    // ****************************************
    // index to definition hit
    function automatic logic is_def(input logic [7:0] idx);
        return idx >= idc_pkg::IDX_DEF_BASE &&
               idx < idc_pkg::IDX_DEF_BASE + 8'(2 * idc_pkg::NUM_SRC);
    endfunction

    // lowest set bit
    function automatic logic [1:0] low_one(input logic [3:0] v);
        logic [1:0] r;
        r = 2'd0;
        for (int i = 3; i >= 0; i--) begin
            if (v[i]) begin
                r = 2'(i);
            end
        end
        return r;
    endfunction

    always_comb begin
        dp_def = is_def(index_ff);   // R8
        dp_src = index_ff[2:1];      // R8
        dp_hi  = index_ff[0];        // R9
        dp_wr  = cfg_wr && cfg_addr == idc_pkg::OFF_DATAPORT; // R5
    end

    // ****************************************
    // index register
    // ****************************************
    // only the index byte of the header is writable
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            index_ff <= 8'h00;
        end else if (cfg_wr && cfg_addr == idc_pkg::OFF_HEADER) begin
            index_ff <= cfg_wdata[idc_pkg::IDX_MSB:idc_pkg::IDX_LSB]; // R4
        end
    end

    // ****************************************
    // pin synchroniser and filter
    // ****************************************
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            sync1_ff <= 4'h0;
            sync2_ff <= 4'h0;
            sync3_ff <= 4'h0;
            level_ff <= 4'h0;
        end else begin
            sync1_ff <= irq_in;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            // change accepted once stages two and three agree
            for (int i = 0; i < 4; i++) begin
                if (sync2_ff[i] == sync3_ff[i]) begin
                    level_ff[i] <= sync3_ff[i];
                end
            end
        end
    end

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            active[i] = level_ff[i] ^ def_ff[i][idc_pkg::B_POL]; // R19
        end
        fire = active & ~prev_ff;
    end

    // ****************************************
    // activation edge and pending requests
    // ****************************************
    // a rising activation is one request; a level held does not repeat
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            prev_ff <= 4'h0;
            pend_ff <= 4'h0;
        end else begin
            prev_ff <= active;
            for (int i = 0; i < 4; i++) begin
                if (fire[i]) begin
                    pend_ff[i] <= 1'b1;              // R21
                end else if (sent && sel_ff == 2'(i)) begin
                    pend_ff[i] <= 1'b0;
                end
            end
        end
    end

    // masked or awaiting eoi sources keep their request parked
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            eligible[i] = pend_ff[i] &&
                !def_ff[i][idc_pkg::B_MASK] &&           // R20
                !def_ff[i][idc_pkg::B_WAIT];             // R12
        end
        pick = low_one(eligible);
        sent = state_ff == IDC_SEND && msg_ready;
    end

    // ****************************************
    // sender state machine
    // ****************************************
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_ff <= IDC_IDLE;
            sel_ff   <= 2'd0;
        end else begin
            unique case (state_ff)
                IDC_IDLE: begin
                    if (|eligible) begin
                        sel_ff   <= pick;
                        state_ff <= IDC_ORDER;
                    end
                end
                IDC_ORDER: begin
                    // unordered messages skip the posted drain
                    if (def_ff[sel_ff][idc_pkg::B_PASS_POSTED_WRITES] ||   // R13
                        !posted_pending) begin                 // R14
                        state_ff <= IDC_SEND;
                    end
                end
                IDC_SEND: begin
                    if (msg_ready) begin
                        state_ff <= IDC_IDLE;
                    end
                end
            endcase
        end
    end

    // message fields taken live from the chosen definition
    always_comb begin
        msg_valid              = state_ff == IDC_SEND;
        msg_info               = def_ff[sel_ff][55:0];           // R21
        msg_pass_posted_writes = def_ff[sel_ff][idc_pkg::B_PASS_POSTED_WRITES]; // R13
        msg_src                = sel_ff;
    end

    // ****************************************
    // definition registers
    // ****************************************
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < 4; i++) begin
                def_ff[i] <= idc_pkg::DEF_RESET;   // R10 R16 R18 R20
                // a fixed ordering bit never shows the other behaviour
                if (PASS_POSTED_WRITES_FIXED) begin
                    def_ff[i][idc_pkg::B_PASS_POSTED_WRITES] <= PASS_POSTED_WRITES_VALUE; // R15
                end
            end
        end else begin
            for (int i = 0; i < 4; i++) begin
                // software field writes
                if (dp_wr && dp_def && dp_src == 2'(i)) begin
                    if (dp_hi) begin
                        def_ff[i][62:32] <= (def_ff[i][62:32] &
                            ~idc_pkg::DEF_WMASK[62:32]) |
                            (cfg_wdata[30:0] &
                             idc_pkg::DEF_WMASK[62:32]);      // R9
                    end else begin
                        def_ff[i][31:0] <= cfg_wdata;  // R9 R16 R18
                    end
                end
                if (PASS_POSTED_WRITES_FIXED) begin
                    def_ff[i][idc_pkg::B_PASS_POSTED_WRITES] <= PASS_POSTED_WRITES_VALUE; // R15
                end
                // set on send wins over eoi or software clear
                if (sent && sel_ff == 2'(i) &&
                    def_ff[i][idc_pkg::B_REQUEST_END_OF_INTERRUPT]) begin
                    def_ff[i][idc_pkg::B_WAIT] <= 1'b1;           // R11
                end else if (eoi_in[i] ||
                    (dp_wr && dp_def && dp_hi && dp_src == 2'(i) &&
                     cfg_wdata[31])) begin
                    def_ff[i][idc_pkg::B_WAIT] <= 1'b0;           // R11
                end
            end
        end
    end

    // ****************************************
    // read path
    // ****************************************
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            defs_flat[i*64 +: 64] = def_ff[i];
        end
        rif.rd_addr = {4'h0, dp_src, dp_hi};
    end

    idc_read_mux u_rd (
        .core_clk (core_clk),
        .rstn     (rstn),
        .defs     (defs_flat),
        .rp       (rif.mem)
    );

    // fixed words captured alongside the definition read
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rd_hdr_ff  <= 1'b0;
            rd_def_ff  <= 1'b0;
            rd_fix_ff  <= 32'h0000_0000;
            cfg_rvalid <= 1'b0;
        end else begin
            cfg_rvalid <= cfg_rd;
            rd_hdr_ff  <= cfg_addr == idc_pkg::OFF_HEADER;
            rd_def_ff  <= dp_def;
            if (cfg_addr == idc_pkg::OFF_HEADER) begin
                rd_fix_ff <= {idc_pkg::CAP_TYPE_VAL, index_ff,  // R1 R3
                              NEXT_PTR, idc_pkg::CAP_ID_VAL};   // R2
            end else if (index_ff == idc_pkg::IDX_LAST_INTR) begin
                rd_fix_ff <= {8'h00, 8'(idc_pkg::NUM_SRC - 1),
                              16'h0000};                        // R7
            end else begin
                rd_fix_ff <= 32'h0000_0000;                     // R6
            end
        end
    end

    always_comb begin
        if (!rd_hdr_ff && rd_def_ff) begin
            cfg_rdata = rif.rd_data;
        end else begin
            cfg_rdata = rd_fix_ff;
        end
    end
endmodule // idc_top

/* testbench/idc_assertions.sv */
`timescale 1ns/1ps
// ****************************************
// port checker for the discovery block
// ****************************************
module idc_chk #(
    parameter logic [7:0] NEXT_PTR = 8'h00
) (
    // clock and reset
    input wire logic        core_clk,
    input wire logic        rstn,
    // configuration access
    input wire logic        cfg_rd,
    input wire logic        cfg_wr,
    input wire logic [1:0]  cfg_addr,
    input wire logic [31:0] cfg_wdata,
    input wire logic [31:0] cfg_rdata,
    input wire logic        cfg_rvalid,
    // upstream message side
    input wire logic        posted_pending,
    input wire logic        msg_valid,
    input wire logic        msg_ready,
    input wire logic        msg_pass_posted_writes,
    input wire logic [1:0]  msg_src
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // decoded access kinds
    wire logic hdr_rd = cfg_rd && cfg_addr == 2'h0;
    wire logic dp_rd  = cfg_rd && cfg_addr == 2'h1;
    wire logic hdr_wr = cfg_wr && cfg_addr == 2'h0;
    property p_rd_answer; cfg_rd |=> cfg_rvalid; endproperty
    a_rd_answer: assert property (p_rd_answer)
        else $error("read not answered");
    property p_rvalid_cause; cfg_rvalid |-> $past(cfg_rd); endproperty
    a_rvalid_cause: assert property (p_rvalid_cause)
        else $error("read answer without read");
    property p_cap_id; hdr_rd |=> cfg_rdata[7:0] == 8'h08; endproperty
    a_cap_id: assert property (p_cap_id)
        else $error("capability id wrong");
    property p_next; hdr_rd |=> cfg_rdata[15:8] == NEXT_PTR; endproperty
    a_next: assert property (p_next)
        else $error("next pointer wrong");
    property p_cap_type; hdr_rd |=> cfg_rdata[31:24] == 8'h80; endproperty
    a_cap_type: assert property (p_cap_type)
        else $error("capability type wrong");
    property p_index_rb;
        hdr_wr ##1 hdr_rd |=> cfg_rdata[23:16] == $past(cfg_wdata[23:16], 2);
    endproperty
    a_index_rb: assert property (p_index_rb)
        else $error("index not kept");
    property p_last;
        hdr_wr && cfg_wdata[23:16] == 8'h01 ##1 dp_rd |=>
            cfg_rdata == 32'h0003_0000;
    endproperty
    a_last: assert property (p_last)
        else $error("last source number wrong");
    property p_undef;
        hdr_wr && !(cfg_wdata[23:16] inside {8'h01, [8'h10:8'h17]}) ##1 dp_rd
            |=> cfg_rdata == 32'h0000_0000;
    endproperty
    a_undef: assert property (p_undef)
        else $error("undefined index not zero");
    property p_msg_hold;
        msg_valid && !msg_ready |=> msg_valid && $stable(msg_src);
    endproperty
    a_msg_hold: assert property (p_msg_hold)
        else $error("message dropped before accept");
    // ordered messages may only leave once posted traffic has drained
    property p_ordered;
        $rose(msg_valid) && !msg_pass_posted_writes |-> !$past(posted_pending);
    endproperty
    a_ordered: assert property (p_ordered)
        else $error("ordered message passed posted traffic");
endmodule // idc_chk

bind idc_top idc_chk #(.NEXT_PTR(NEXT_PTR)) u_chk (.core_clk, .rstn,
    .cfg_rd, .cfg_wr, .cfg_addr, .cfg_wdata, .cfg_rdata, .cfg_rvalid,
    .posted_pending, .msg_valid, .msg_ready, .msg_pass_posted_writes,
    .msg_src);

/* testbench/idc_host_model.sv */
`timescale 1ns/1ps
// ****************************************
// upstream host: takes messages, returns eoi
// ****************************************
module idc_host_model (
    // clock
    input wire logic        core_clk,
    // message from the device
    input wire logic        msg_valid,
    input wire logic [55:0] msg_info,
    input wire logic        msg_pass_posted_writes,
    input wire logic [1:0]  msg_src,
    output logic            msg_ready,
    // returns to the device
    output logic [3:0]      eoi_in,
    output logic            posted_pending
);
    logic [58:0] got_q [$]; // accepted {src, pass, info}
    initial begin
        msg_ready      = 1'b0;
        eoi_in         = 4'h0;
        posted_pending = 1'b0;
    end
    // random stalls, so held requests are exercised
    always @(negedge core_clk) msg_ready <= 1'($urandom % 2);
    // record each accepted message
    always @(posedge core_clk) begin
        if (msg_valid && msg_ready) begin
            got_q.push_back({msg_src, msg_pass_posted_writes, msg_info});
        end
    end
    // one-cycle end of interrupt for a source
    task automatic send_eoi(input int s);
        @(negedge core_clk) eoi_in[s] = 1'b1;
        @(negedge core_clk) eoi_in = 4'h0;
    endtask
    // posted writes queued ahead for n cycles
    task automatic hold_posted(input int n);
        posted_pending = 1'b1;
        repeat (n) @(negedge core_clk);
        posted_pending = 1'b0;
    endtask
endmodule // idc_host_model

/* testbench/testbench.sv */
`timescale 1ns/1ps
module testbench;
    // ****************************************
    // signals and model state
    // ****************************************
    logic        core_clk = 0, rstn = 0, cfg_rd = 0, cfg_wr = 0;
    logic [1:0]  cfg_addr = 0, msg_src;
    logic [31:0] cfg_wdata = 0, cfg_rdata;
    logic [3:0]  irq_in = 0, eoi_in;
    logic [55:0] msg_info;
    logic        cfg_rvalid, posted_pending, msg_valid, msg_ready, msg_pp;
    logic [63:0] mdef [4]; // model definitions
    logic [7:0]  midx;     // model index
    int          fails = 0, tests_run = 0;
    always #5 core_clk = ~core_clk;
    idc_top dut (.core_clk, .rstn, .cfg_rd, .cfg_wr, .cfg_addr, .cfg_wdata,
        .cfg_rdata, .cfg_rvalid, .irq_in, .eoi_in, .posted_pending,
        .msg_valid, .msg_ready, .msg_info, .msg_pass_posted_writes(msg_pp),
        .msg_src);
    idc_host_model host (.core_clk, .msg_valid, .msg_info, .msg_src,
        .msg_pass_posted_writes(msg_pp), .msg_ready, .eoi_in, .posted_pending);
    // copy with the ordering bit fixed, sharing the same bus
    logic [31:0] fix_rdata;
    idc_top #(.PASS_POSTED_WRITES_FIXED(1'b1), .PASS_POSTED_WRITES_VALUE(1'b1)) dut_fix (.core_clk,
        .rstn, .cfg_rd, .cfg_wr, .cfg_addr, .cfg_wdata,
        .cfg_rdata(fix_rdata), .cfg_rvalid(), .irq_in, .eoi_in,
        .posted_pending, .msg_valid(), .msg_ready, .msg_info(),
        .msg_pass_posted_writes(), .msg_src());
    // ****************************************
    // shared tasks, all entered at a falling edge
    // ****************************************
    task automatic check(input logic [63:0] got, exp, input string what);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: %s %h vs %h", $time, what, got, exp);
        end
    endtask
    task automatic final_report;
        if (fails == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic model_reset;
        midx = 8'h00;
        foreach (mdef[i]) mdef[i] = 64'h0000_0000_F800_0001;
    endtask
    // move only the strobes that change; write and read can swap in one step
    task automatic strobe(input logic w, input logic r);
        if (cfg_wr != w) cfg_wr = w;
        if (cfg_rd != r) cfg_rd = r;
    endtask
    task automatic wr(input logic [1:0] a, input logic [31:0] d);
        logic [63:0] wm;
        wm = idc_pkg::DEF_WMASK;
        {cfg_addr, cfg_wdata} = {a, d};
        strobe(1'b1, 1'b0); // held up across back-to-back writes
        @(negedge core_clk);
        if (a == 2'h0) midx = d[23:16]; // only the index is writable
        else if (midx inside {[8'h10:8'h17]} && !midx[0]) begin
            mdef[midx[2:1]][31:0] = mdef[midx[2:1]][31:0] & ~wm[31:0]
                | d & wm[31:0];
        end else if (midx inside {[8'h10:8'h17]}) begin
            mdef[midx[2:1]][63:32] = mdef[midx[2:1]][63:32] & ~wm[63:32]
                | d & wm[63:32];
            if (d[31]) mdef[midx[2:1]][63] = 1'b0; // write one clears
        end
    endtask
    task automatic rd(input logic [1:0] a);
        logic [31:0] e;
        e = 32'h0000_0000; // undefined indexes
        if (a == 2'h0) e = {8'h80, midx, 8'h00, 8'h08};
        else if (midx == 8'h01) e = 32'h0003_0000;
        else if (midx inside {[8'h10:8'h17]}) begin
            e = midx[0] ? mdef[midx[2:1]][63:32] : mdef[midx[2:1]][31:0];
        end
        cfg_addr = a;
        strobe(1'b0, 1'b1);
        @(negedge core_clk);
        check(cfg_rvalid, 1, "read valid");
        check(cfg_rdata, e, "read data");
        if (a == 2'h1 && midx inside {[8'h10:8'h17]} && midx[0])
            check(fix_rdata[30], 1'b1, "fixed ordering bit");
    endtask
    // select an index, optionally write the dataport, read it back
    task automatic acc(input logic [7:0] i, input logic [31:0] d, bit w);
        wr(2'h0, {8'h00, i, 16'h0000});
        if (w) wr(2'h1, d);
        rd(2'h1);
        strobe(1'b0, 1'b0); // bus idle after each access
    endtask
    // header first, then indexes 00h-1Fh and FFh, ending on an idle bus
    task automatic scan;
        rd(2'h0);
        for (int i = 0; i < 32; i++) acc(8'(i), 0, 0);
        acc(8'hFF, 0, 0);
    endtask
    task automatic wait_msg(input int s);
        int n;
        for (n = 0; host.got_q.size() == 0 && n < 300; n++) @(negedge core_clk);
        check(n < 300, 1, "message missing");
        if (n < 300) begin
            check(host.got_q.pop_front(), {2'(s), mdef[s][62],
                mdef[s][55:0]}, "message");
            if (mdef[s][5]) mdef[s][63] = 1'b1; // now awaiting eoi
        end
    endtask
    // one activation at the configured polarity, then back to idle
    task automatic act(input int s);
        irq_in[s] = ~mdef[s][1];
        repeat (8) @(negedge core_clk);
        irq_in[s] = mdef[s][1];
        repeat (8) @(negedge core_clk);
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        logic [31:0] r;
        void'($urandom(67553));
        model_reset;
        repeat (3) @(negedge core_clk);
        rstn = 1'b1;
        scan;
        for (int k = 0; k < 24; k++) begin
            r = $urandom;
            if (!r[24]) r[1:0] = 2'b01; // keep masked and active-high
            if (!r[24] && r[31:24] > 8'hF8) r[31:24] = 8'hF8;
            acc({3'h0, r[28:24]}, r, 1);
        end
        wr(2'h0, $urandom); rd(2'h0);
        strobe(1'b0, 1'b0);
        for (int s = 0; s < 4; s++) begin
            r = $urandom;
            acc(8'h11 + 8'(2 * s), {1'b0, s[1], 6'h00, r[23:0]}, 1);
            acc(8'h10 + 8'(2 * s), {8'hF8, r[23:6], 1'b0, r[4:2], s[0],
                1'b0}, 1);
            irq_in[s] = s[0]; // idle level for the polarity
            repeat (30) @(negedge core_clk);
            host.got_q.delete(); // stale activation from reconfiguring
            acc(8'h10 + 8'(2 * s), mdef[s][31:0] | 32'h0000_0020, 1);
            if (!s[1]) fork host.hold_posted(40); join_none
            act(s); wait_msg(s);
            acc(8'h11 + 8'(2 * s), 0, 0);
            act(s); repeat (20) @(negedge core_clk);
            check(host.got_q.size(), 0, "sent while awaiting");
            host.send_eoi(s); mdef[s][63] = 1'b0;
            wait_msg(s);
            acc(8'h11 + 8'(2 * s), {1'b1, mdef[s][62:32]}, 1);
            acc(8'h10 + 8'(2 * s), mdef[s][31:0] | 32'h0000_0001, 1);
            act(s); repeat (20) @(negedge core_clk);
            check(host.got_q.size(), 0, "sent while masked");
            acc(8'h10 + 8'(2 * s), mdef[s][31:0] & 32'hFFFF_FFFE, 1);
            wait_msg(s);
        end
        rstn = 1'b0;
        repeat (3) @(negedge core_clk);
        rstn = 1'b1;
        model_reset;
        scan;
        final_report;
    end
    // watchdog well past the expected run length
    initial begin
        #300_000;
        fails++;
        final_report;
    end
endmodule // testbench
